// file: logic/watch_reset_regs.vh
`ifndef WATCH_RESET_REGS_VH
`define WATCH_RESET_REGS_VH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_TALLY 12'h008
`define OFS_KEEP 12'h00C
`define OFS_DEFAULTS 12'h010
// Control fields
`define CTRL_STBY_WATCH 0
`define CTRL_INPUT_TYPE 1
`define CTRL_IRQ_MASK 2
`define CTRL_MUX_EN 3
// Tally register fields
`define TALLY_LSB 0
`define LIMIT_LSB 8
`define TALLY_W 4
// Reset values
`define CTRL_RESET 4'h0
`define TALLY_ZERO 4'h0
// Status fields
`define ST_STATE_LSB 0
`define ST_IRQ 4
`define ST_HOST_RST 5
`define ST_POWER_GOOD_OUT 6
`define ST_STBY 7
// Timing
`define SETTLE_NS 30000
`define CLK_NS 100
`endif

// file: logic/settle_timer.v
`timescale 1ns/10ps
module settle_timer #(
   parameter CYCLES = 300
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire start,
   output wire done
);
   reg [15:0] count_reg;
   reg running_reg;
   assign done = running_reg && (count_reg == 16'h0000);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 16'h0000;
         running_reg <= 1'b0;
      end else if (start) begin
         count_reg <= CYCLES[15:0] - 16'h0001;
         running_reg <= 1'b1;
      end else if (done) begin
         running_reg <= 1'b0;
      end else if (running_reg) begin
         count_reg <= count_reg - 16'h0001;
      end
   end
endmodule

// file: logic/regulator_restore.v
`timescale 1ns/10ps
module regulator_restore #(
   parameter N = 7,
   parameter NSW = 5
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Request
   input wire soft_go,
   input wire hard_go,
   input wire [N-1:0] keep,
   input wire [N-1:0] in_seq,
   // Status
   output wire all_settled,
   output reg [N-1:0] reg_on,
   output reg [N-1:0] ramping,
   output reg [N-1:0] restored
);
   wire [N-1:0] ramp_done_in;
   assign all_settled = ~|ramping;
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_reg
         reg [2:0] ramp_reg;
         assign ramp_done_in[i] = (ramp_reg == 3'h0);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               reg_on[i] <= 1'b1;
               ramping[i] <= 1'b0;
               restored[i] <= 1'b0;
               ramp_reg <= 3'h0;
            end else if (hard_go) begin
               reg_on[i] <= 1'b0;
               ramping[i] <= 1'b0;
               restored[i] <= 1'b1;
            end else if (soft_go && !keep[i]) begin
               restored[i] <= 1'b1;
               if (!in_seq[i]) begin
                  reg_on[i] <= 1'b0;
                  ramping[i] <= 1'b0;
               end else if (i < NSW) begin
                  reg_on[i] <= 1'b1;
                  ramping[i] <= 1'b1;
                  ramp_reg <= 3'h7;
               end else begin
                  reg_on[i] <= 1'b1;
                  ramping[i] <= 1'b0;
               end
            end else if (soft_go) begin
               restored[i] <= 1'b0;
            end else if (ramping[i]) begin
               if (ramp_done_in[i])
                  ramping[i] <= 1'b0;
               else
                  ramp_reg <= ramp_reg - 3'h1;
            end
         end
      end
   endgenerate
endmodule

// file: logic/watchdog_reset_manager.v
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "watch_reset_regs.vh"
module watchdog_reset_manager #(
   parameter N = 7,
   parameter NSW = 5
) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Fuse defaults
   input wire fuse_standby_watch_default,
   input wire [3:0] fuse_watch_event_limit,
   input wire [N-1:0] fuse_in_sequence,
   input wire fuse_power_good_out_in_sequence,
   // Events and pins
   input wire watch_input_pin,
   input wire timer_expired,
   input wire standby_pin,
   input wire fail_line_n,
   input wire power_off_pass,
   // Outputs
   output wire watch_timer_run,
   output reg host_reset_out_n,
   output reg power_good_out,
   output reg irq_out_n,
   output reg standby_state,
   output reg fail_safe,
   output reg reload_subset,
   output reg reload_all,
   output reg power_up_go,
   output wire [N-1:0] regulator_on,
   output wire [N-1:0] regulator_ramping,
   output reg analog_mux_enable
);
   localparam SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS;
   localparam S_RUN = 3'h0;
   localparam S_SOFT = 3'h1;
   localparam S_SOFT_WAIT = 3'h2;
   localparam S_HARD = 3'h3;
   localparam S_HARD_WAIT = 3'h4;
   localparam S_FAIL = 3'h5;
   localparam S_HOLD = 3'h6;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg standby_watch_enable;
   reg watch_input_reset_type;
   reg watch_input_irq_mask;
   reg watch_input_irq_flag;
   reg [3:0] watch_event_tally;
   reg [3:0] watch_event_limit;
   reg [N-1:0] keep_reg;
   reg defaults_loaded_reg;
   reg pin_prev_reg;
   reg settle_start;
   wire settle_done;
   wire all_settled;
   wire [N-1:0] restored;
   wire input_event;
   wire watch_event;
   wire soft_go;
   wire hard_go;
   wire at_limit;
   wire wr;
   wire rd;
   wire clr_irq;
   wire wr_ctrl;
   wire wr_status;
   wire wr_tally;
   wire wr_keep;
   wire soft_done;
   wire hard_done;

   // Register offset match
   function addr_hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         addr_hit = (addr == ofs);
      end
   endfunction

   // Bus decode
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign wr_ctrl = wr && addr_hit(paddr, `OFS_CTRL);
   assign wr_status = wr && addr_hit(paddr, `OFS_STATUS);
   assign wr_tally = wr && addr_hit(paddr, `OFS_TALLY);
   assign wr_keep = wr && addr_hit(paddr, `OFS_KEEP);
   assign clr_irq = wr_status && pwdata[`ST_IRQ];
   assign input_event = pin_prev_reg && !watch_input_pin;
   assign watch_event = (state_reg == S_RUN) && (input_event || timer_expired);
   assign at_limit = (watch_event_tally == watch_event_limit);
   assign soft_go = watch_event && !at_limit && !timer_expired && !watch_input_reset_type;
   assign hard_go = watch_event && !at_limit && !soft_go;
   assign watch_timer_run = !standby_state || standby_watch_enable;
   assign soft_done = (state_reg == S_SOFT_WAIT) && settle_done;
   assign hard_done = (state_reg == S_HARD_WAIT) && settle_done;

   // Settle timer
   settle_timer #(
      .CYCLES(SETTLE_CYC)
   ) u_settle (
      .pclk(pclk),
      .presetn(presetn),
      .start(settle_start),
      .done(settle_done)
   );

   // Regulator restore
   regulator_restore #(
      .N(N),
      .NSW(NSW)
   ) u_restore (
      .pclk(pclk),
      .presetn(presetn),
      .soft_go(soft_go),
      .hard_go(hard_go),
      .keep(keep_reg),
      .in_seq(fuse_in_sequence),
      .all_settled(all_settled),
      .reg_on(regulator_on),
      .ramping(regulator_ramping),
      .restored(restored)
   );

   // Next state
   always @* begin
      state_next = state_reg;
      settle_start = 1'b0;
      case (state_reg)
         S_RUN: begin
            if (watch_event && at_limit)
               state_next = S_FAIL;
            else if (soft_go)
               state_next = S_SOFT;
            else if (hard_go)
               state_next = S_HARD;
         end
         S_SOFT: begin
            if (all_settled) begin
               settle_start = 1'b1;
               state_next = S_SOFT_WAIT;
            end
         end
         S_SOFT_WAIT: begin
            if (settle_done)
               state_next = S_RUN;
         end
         S_HARD: begin
            settle_start = 1'b1;
            state_next = S_HARD_WAIT;
         end
         S_HARD_WAIT: begin
            if (settle_done)
               state_next = fail_line_n ? S_RUN : S_HOLD;
         end
         S_HOLD: begin
            if (fail_line_n)
               state_next = S_RUN;
         end
         S_FAIL: begin
            state_next = S_FAIL;
         end
         default: begin
            state_next = S_RUN;
         end
      endcase
   end

   // State and reload strobes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_RUN;
         pin_prev_reg <= 1'b1;
         fail_safe <= 1'b0;
         reload_subset <= 1'b0;
         reload_all <= 1'b0;
         power_up_go <= 1'b0;
      end else begin
         state_reg <= state_next;
         pin_prev_reg <= watch_input_pin;
         reload_subset <= soft_go;
         reload_all <= hard_done;
         power_up_go <= (hard_done || (state_reg == S_HOLD)) && fail_line_n;
         fail_safe <= fail_safe || (watch_event && at_limit);
      end
   end

   // Host reset and power good
   // soft path never touches host reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_reset_out_n <= 1'b1;
         power_good_out <= 1'b1;
      end else if (hard_go) begin
         host_reset_out_n <= 1'b0;
         if (fuse_power_good_out_in_sequence)
            power_good_out <= 1'b0;
      end else if (power_up_go) begin
         host_reset_out_n <= 1'b1;
         power_good_out <= 1'b1;
      end
   end

   // Completion flag and interrupt pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watch_input_irq_flag <= 1'b0;
         irq_out_n <= 1'b1;
      end else begin
         if (soft_done)
            watch_input_irq_flag <= 1'b1;
         else if (clr_irq)
            watch_input_irq_flag <= 1'b0;
         irq_out_n <= !(watch_input_irq_flag && !watch_input_irq_mask);
      end
   end

   // Standby follows its pin in run
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_state <= 1'b0;
      end else if ((state_reg == S_RUN) || (state_next == S_RUN)) begin
         standby_state <= standby_pin;
      end
   end

   // Settings and their default loads
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         defaults_loaded_reg <= 1'b0;
         standby_watch_enable <= 1'b0;
         watch_input_reset_type <= 1'b0;
         watch_input_irq_mask <= 1'b0;
         analog_mux_enable <= 1'b0;
         watch_event_limit <= `TALLY_ZERO;
         keep_reg <= {N{1'b0}};
      end else if (!defaults_loaded_reg || reload_all) begin
         defaults_loaded_reg <= 1'b1;
         standby_watch_enable <= fuse_standby_watch_default;
         watch_input_reset_type <= 1'b0;
         watch_input_irq_mask <= 1'b0;
         watch_event_limit <= fuse_watch_event_limit;
         analog_mux_enable <= 1'b0;
         keep_reg <= {N{1'b0}};
      end else if (soft_go) begin
         standby_watch_enable <= fuse_standby_watch_default;
         analog_mux_enable <= 1'b0;
         keep_reg <= {N{1'b0}};
      end else if (wr_ctrl) begin
         standby_watch_enable <= pwdata[`CTRL_STBY_WATCH];
         watch_input_reset_type <= pwdata[`CTRL_INPUT_TYPE];
         watch_input_irq_mask <= pwdata[`CTRL_IRQ_MASK];
         analog_mux_enable <= pwdata[`CTRL_MUX_EN];
      end else if (wr_keep) begin
         keep_reg <= pwdata[N-1:0];
      end
   end

   // Watch event tally
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watch_event_tally <= `TALLY_ZERO;
      end else if (power_off_pass) begin
         watch_event_tally <= `TALLY_ZERO;
      end else if (watch_event && !at_limit) begin
         watch_event_tally <= watch_event_tally + 4'h1;
      end else if (wr_tally) begin
         watch_event_tally <= `TALLY_ZERO;
      end
   end

   // Readback mux
   always @* begin
      prdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            `OFS_CTRL: begin
               prdata[`CTRL_STBY_WATCH] = standby_watch_enable;
               prdata[`CTRL_INPUT_TYPE] = watch_input_reset_type;
               prdata[`CTRL_IRQ_MASK] = watch_input_irq_mask;
               prdata[`CTRL_MUX_EN] = analog_mux_enable;
            end
            `OFS_STATUS: begin
               prdata[`ST_STATE_LSB+2:`ST_STATE_LSB] = state_reg;
               prdata[`ST_IRQ] = watch_input_irq_flag;
               prdata[`ST_HOST_RST] = host_reset_out_n;
               prdata[`ST_POWER_GOOD_OUT] = power_good_out;
               prdata[`ST_STBY] = standby_state;
            end
            `OFS_TALLY: begin
               prdata[`TALLY_LSB+3:`TALLY_LSB] = watch_event_tally;
               prdata[`LIMIT_LSB+3:`LIMIT_LSB] = watch_event_limit;
            end
            `OFS_KEEP: begin
               prdata[N-1:0] = keep_reg;
            end
            `OFS_DEFAULTS: begin
               prdata[N-1:0] = restored;
            end
            default: begin
               prdata = 32'h0000_0000;
            end
         endcase
      end
   end
endmodule

// file: tb/watch_reset_props.sv
`timescale 1ns/10ps
module watch_reset_props #(
   parameter N = 7,
   parameter NSW = 5
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Watched signals
   input wire fail_line_n,
   input wire fuse_power_good_out_in_sequence,
   input wire watch_timer_run,
   input wire standby_state,
   input wire host_reset_out_n,
   input wire power_good_out,
   input wire fail_safe,
   input wire reload_subset,
   input wire reload_all,
   input wire power_up_go,
   input wire [N-1:0] regulator_on,
   input wire [N-1:0] regulator_ramping
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_timer_gate: assert property (!standby_state |-> watch_timer_run)
      else $error("watch timer stopped outside standby");
   a_one_kind: assert property (!(reload_all && reload_subset))
      else $error("soft and hard reload together");
   a_soft_host_up: assert property (reload_subset |-> host_reset_out_n [*8])
      else $error("host reset asserted in soft reset");
   a_linear_step: assert property (regulator_ramping[N-1:NSW] == '0)
      else $error("linear regulator ramping");
   a_hard_all_off: assert property ($fell(host_reset_out_n) |-> regulator_on == '0)
      else $error("regulator left on in hard reset");
   a_hard_host_low: assert property (reload_all |-> !host_reset_out_n)
      else $error("host reset released before reload");
   a_power_good_out_drop: assert property (
      $fell(host_reset_out_n) && fuse_power_good_out_in_sequence |-> ##[0:1] !power_good_out)
      else $error("power good not dropped");
   a_hard_settle: assert property ($fell(host_reset_out_n) |-> ##[300:303] reload_all)
      else $error("hard reload not after settle time");
   a_fail_hold: assert property (power_up_go |-> $past(fail_line_n))
      else $error("power up while fail line low");
   a_fail_sticky: assert property (fail_safe |=> fail_safe)
      else $error("fail safe dropped");
endmodule

bind watchdog_reset_manager watch_reset_props #(.N(N), .NSW(NSW)) i_props (.*);

// file: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire pclk,
   // APB master
   output reg psel,
   output reg penable,
   output reg pwrite,
   output reg [11:0] paddr,
   output reg [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   // Watch pin
   output reg watch_input_pin
);
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      watch_input_pin = 1'h1;
   end
   // One APB transfer
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      pwdata <= ~d;
   endtask
   // Watch pin level
   task pin(input logic v);
      @(posedge pclk);
      watch_input_pin <= v;
   endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
`include "watch_reset_regs.vh"
module tb;
   reg pclk, presetn, timer_expired, standby_pin, fail_line_n, power_off_pass;
   reg fuse_standby_watch_default, fuse_power_good_out_in_sequence;
   wire psel, penable, pwrite, pready, pslverr, watch_input_pin;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire watch_timer_run, host_reset_out_n, power_good_out, irq_out_n, standby_state;
   wire fail_safe, reload_subset, reload_all, power_up_go, analog_mux_enable;
   wire [6:0] regulator_on, regulator_ramping;
   integer n_fail = 0, total_checks = 0, cycles = 0;
   logic [31:0] rd;
   watchdog_reset_manager i_dut (.*, .fuse_watch_event_limit(4'h2), .fuse_in_sequence(7'h55));
   host_model i_host (.*);
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   task final_report;
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      i_host.apb(1'h1, a, d, rd);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      i_host.apb(1'h0, a, 32'h0, rd);
      check(rd, e);
   endtask
   task do_soft(output int n);
      wr(`OFS_STATUS, 32'h10);
      i_host.pin(1'h0);
      @(posedge pclk iff reload_subset === 1'h1);
      i_host.pin(1'h1);
      n = 0;
      while (irq_out_n !== 1'h0) begin
         @(posedge pclk);
         n = n + 1;
      end
   endtask
   task t_defaults;
      rdc(`OFS_CTRL, 32'h1);
      rdc(`OFS_TALLY, 32'h200);
   endtask
   task t_standby;
      standby_pin <= 1'h1;
      wr(`OFS_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      check(32'(standby_state), 32'h1);
      check(32'(watch_timer_run), 32'h0);
      wr(`OFS_CTRL, 32'h1);
      @(posedge pclk);
      check(32'(watch_timer_run), 32'h1);
      standby_pin <= 1'h0;
   endtask
   task t_soft;
      int n;
      wr(`OFS_KEEP, 32'h2);
      wr(`OFS_CTRL, 32'h8);
      @(posedge pclk);
      check(32'(analog_mux_enable), 32'h1);
      do_soft(n);
      check(32'(n >= 300), 32'h1);
      check(32'(host_reset_out_n), 32'h1);
      check(32'(regulator_on), 32'h57);
      check(32'(analog_mux_enable), 32'h0);
      rdc(`OFS_CTRL, 32'h1);
      rdc(`OFS_DEFAULTS, 32'h7D);
      rdc(`OFS_TALLY, 32'h201);
      wr(`OFS_CTRL, 32'h5);
      repeat (2) @(posedge pclk);
      check(32'(irq_out_n), 32'h1);
      wr(`OFS_CTRL, 32'h1);
      wr(`OFS_TALLY, 32'h0);
      rdc(`OFS_TALLY, 32'h200);
   endtask
   task t_hard;
      wr(`OFS_CTRL, 32'hC);
      fail_line_n <= 1'h0;
      timer_expired <= 1'h1;
      @(posedge pclk);
      timer_expired <= 1'h0;
      @(posedge pclk iff reload_all === 1'h1);
      check(32'(regulator_on), 32'h0);
      check(32'(host_reset_out_n), 32'h0);
      check(32'(power_good_out), 32'h0);
      repeat (5) @(posedge pclk);
      check(32'(power_up_go), 32'h0);
      fail_line_n <= 1'h1;
      @(posedge pclk iff power_up_go === 1'h1);
      repeat (2) @(posedge pclk);
      check(32'(host_reset_out_n), 32'h1);
      rdc(`OFS_CTRL, 32'h1);
      power_off_pass <= 1'h1;
      @(posedge pclk);
      power_off_pass <= 1'h0;
      rdc(`OFS_TALLY, 32'h200);
   endtask
   task t_limit;
      int n;
      do_soft(n);
      check(32'(n >= 300), 32'h1);
      wr(`OFS_CTRL, 32'h2);
      i_host.pin(1'h0);
      @(posedge pclk iff reload_all === 1'h1);
      check(32'(host_reset_out_n), 32'h0);
      check(32'(power_up_go), 32'h1);
      i_host.pin(1'h1);
      rdc(`OFS_TALLY, 32'h202);
      i_host.pin(1'h0);
      repeat (3) @(posedge pclk);
      check(32'(fail_safe), 32'h1);
      rdc(`OFS_TALLY, 32'h202);
   endtask
   initial begin
      presetn = 1'h0;
      timer_expired = 1'h0;
      standby_pin = 1'h0;
      fail_line_n = 1'h1;
      power_off_pass = 1'h0;
      fuse_standby_watch_default = 1'h1;
      fuse_power_good_out_in_sequence = 1'h1;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
      t_defaults;
      t_standby;
      t_soft;
      t_hard;
      t_limit;
      final_report;
   end
endmodule
